// ### core/ifb_defines.vh
`ifndef IFB_DEFINES_VH
`define IFB_DEFINES_VH
// register indices; the bus byte address is the index times four
`define IFB_ADDR_BANK_CTRL   8'hAB
`define IFB_ADDR_ADDR_LO     8'hAC
`define IFB_ADDR_ADDR_HI     8'hAD
`define IFB_ADDR_DATA_BUF    8'hAE
`define IFB_ADDR_OP_MODE     8'hAF
`define IFB_ADDR_CHIP_CTRL   8'hB4
`define IFB_ADDR_IDLE_REQ    8'hB8
`define IFB_ADDR_STATUS      8'hBC
// field positions
`define IFB_BIT_BANK         7
`define IFB_BIT_ARRAY_SEL    6
`define IFB_BIT_OE_N         5
`define IFB_BIT_CE_N         4
`define IFB_BIT_BANKING_EN   3
`define IFB_BIT_PROG_EN      0
// reset values
`define IFB_RST_BANK_CTRL    8'h07
`define IFB_RST_OP_MODE      8'h30
// operation codes
`define IFB_OP_READ          4'h0
`define IFB_OP_PROGRAM       4'h1
`define IFB_OP_ERASE         4'h2
// array geometry
`define IFB_LOADER_BYTES     17'h01000
`define IFB_MAIN_BYTES       17'h10000
`endif

// ### core/ifb_flash_mem.v
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// flash array model: one byte port, registered read data
// ---------------------------------------------------------------
module ifb_flash_mem #(
  parameter AW = 17
) (
  // clock
  input  wire          aclk,
  // access
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  output reg  [7:0]    rdata
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ### core/ifb_isp_flash.v
`timescale 1ns/10ps
`default_nettype none
`include "ifb_defines.vh"
module ifb_isp_flash #(
  parameter LD_AW = 12,
  parameter AP_AW = 16
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // port 1 and core
  input  wire [7:0]  port1_in,
  output reg         cpu_hold,
  output reg         flash_ce_n,
  output reg         flash_oe_n,
  output wire [16:0] code_addr_hi_sel
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_RUN   = 4'b0010;
  localparam ST_WAIT  = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [7:0]  bank_ctrl_ff;
  reg [7:0]  addr_lo_ff;
  reg [7:0]  addr_hi_ff;
  reg [7:0]  data_buf_ff;
  reg [7:0]  op_mode_ff;
  reg        prog_en_ff;
  reg [3:0]  state_ff;
  reg [3:0]  nxt_state;
  reg [16:0] cnt_ff;
  reg        busy_err_ff;
  reg        bad_op_ff;
  reg        aw_ff;
  reg        w_ff;
  reg [9:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg [7:0]  p1_a_ff;
  reg [7:0]  p1_b_ff;
  reg [7:0]  p1_c_ff;
  reg        a16_ff;

  wire [3:0] op_code  = op_mode_ff[3:0];
  wire       sel_ld   = op_mode_ff[`IFB_BIT_ARRAY_SEL];
  wire       sel_bank = op_mode_ff[`IFB_BIT_BANK];
  wire [15:0] faddr   = {addr_hi_ff, addr_lo_ff};

  // ---------------------------------------------------------------
  // flash arrays
  // ---------------------------------------------------------------
  reg         ld_we;
  reg         ap0_we;
  reg         ap1_we;
  reg  [15:0] mem_addr;
  reg  [7:0]  mem_wdata;
  wire [7:0]  ld_rd;
  wire [7:0]  ap0_rd;
  wire [7:0]  ap1_rd;

  ifb_flash_mem #(.AW(LD_AW)) u_loader_flash (
    .aclk  (aclk),
    .we    (ld_we),
    .addr  (mem_addr[LD_AW-1:0]),
    .wdata (mem_wdata),
    .rdata (ld_rd)
  );
  ifb_flash_mem #(.AW(AP_AW)) u_main_flash_bank_lo (
    .aclk  (aclk),
    .we    (ap0_we),
    .addr  (mem_addr[AP_AW-1:0]),
    .wdata (mem_wdata),
    .rdata (ap0_rd)
  );
  ifb_flash_mem #(.AW(AP_AW)) u_main_flash_bank_hi (
    .aclk  (aclk),
    .we    (ap1_we),
    .addr  (mem_addr[AP_AW-1:0]),
    .wdata (mem_wdata),
    .rdata (ap1_rd)
  );

  wire is_erase = (op_code == `IFB_OP_ERASE);
  wire is_prog  = (op_code == `IFB_OP_PROGRAM);
  wire is_read  = (op_code == `IFB_OP_READ);
  // erase sweeps the array as built, so a narrow bank erases quickly
  wire [16:0] ld_last    = (17'h00001 << LD_AW) - 17'h00001;
  wire [16:0] ap_last    = (17'h00001 << AP_AW) - 17'h00001;
  wire [16:0] erase_last = sel_ld ? ld_last : ap_last;

  // array steering
  always @* begin
    ld_we     = 1'b0;
    ap0_we    = 1'b0;
    ap1_we    = 1'b0;
    mem_addr  = faddr;
    mem_wdata = data_buf_ff;
    if (state_ff == ST_RUN && !flash_ce_n) begin
      if (is_erase) begin
        mem_addr  = cnt_ff[15:0];
        mem_wdata = 8'hFF;
      end
      if (is_erase || is_prog) begin
        ld_we  = sel_ld;
        ap0_we = !sel_ld && !sel_bank;
        ap1_we = !sel_ld && sel_bank;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite handshake
  // ---------------------------------------------------------------
  wire wr_go = aw_ff && w_ff && !s_axi_bvalid;
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function known_addr;
    input [7:0] a;
    begin
      known_addr = (a == `IFB_ADDR_BANK_CTRL) || (a == `IFB_ADDR_ADDR_LO) ||
                   (a == `IFB_ADDR_ADDR_HI) || (a == `IFB_ADDR_DATA_BUF) ||
                   (a == `IFB_ADDR_OP_MODE) || (a == `IFB_ADDR_CHIP_CTRL) ||
                   (a == `IFB_ADDR_IDLE_REQ) || (a == `IFB_ADDR_STATUS);
    end
  endfunction

  wire wr_hit = wr_go && wstrb_ff[0];
  wire busy   = (state_ff != ST_IDLE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      awaddr_ff    <= 10'h000;
      wdata_ff     <= 32'h00000000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr(awaddr_ff[9:2]) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  wire [7:0] wa    = awaddr_ff[9:2];
  wire [7:0] wbyte = wdata_ff[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      bank_ctrl_ff <= `IFB_RST_BANK_CTRL;
      addr_lo_ff   <= 8'h00;
      addr_hi_ff   <= 8'h00;
      op_mode_ff   <= `IFB_RST_OP_MODE;
      prog_en_ff   <= 1'b0;
      busy_err_ff  <= 1'b0;
    end else if (wr_hit) begin
      if (busy && wa != `IFB_ADDR_STATUS) begin
        busy_err_ff <= 1'b1;
      end else begin
        case (wa)
          `IFB_ADDR_BANK_CTRL: bank_ctrl_ff <= {4'h0, wbyte[3:0]};
          `IFB_ADDR_ADDR_LO:   addr_lo_ff   <= wbyte;
          `IFB_ADDR_ADDR_HI:   addr_hi_ff   <= wbyte;
          `IFB_ADDR_OP_MODE:   op_mode_ff   <= wbyte;
          `IFB_ADDR_CHIP_CTRL: prog_en_ff   <= wbyte[`IFB_BIT_PROG_EN];
          `IFB_ADDR_STATUS:    busy_err_ff  <= busy_err_ff & ~wbyte[2];
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  wire trigger = wr_hit && !busy && (wa == `IFB_ADDR_IDLE_REQ) &&
                 wbyte[0] && prog_en_ff;
  wire op_known = is_erase || is_prog || is_read;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (trigger && op_known) nxt_state = ST_RUN;
      ST_RUN:  if (!is_erase || cnt_ff == erase_last) nxt_state = ST_WAIT;
      ST_WAIT: nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 17'h00000;
      cpu_hold    <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      data_buf_ff <= 8'h00;
      bad_op_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (trigger && !op_known) begin
        bad_op_ff <= 1'b1;
      end else if (trigger) begin
        bad_op_ff <= 1'b0;
      end
      if (state_ff == ST_IDLE && nxt_state == ST_RUN) begin
        cpu_hold   <= 1'b1;
        flash_ce_n <= op_mode_ff[`IFB_BIT_CE_N];
        flash_oe_n <= op_mode_ff[`IFB_BIT_OE_N];
        cnt_ff     <= 17'h00000;
      end
      if (state_ff == ST_RUN) begin
        cnt_ff <= cnt_ff + 17'h00001;
      end
      if (state_ff == ST_DONE) begin
        if (is_read && !flash_ce_n && !flash_oe_n) begin
          data_buf_ff <= sel_ld ? ld_rd : (sel_bank ? ap1_rd : ap0_rd);
        end
        cpu_hold   <= 1'b0;
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
      end
      if (wr_hit && !busy && wa == `IFB_ADDR_DATA_BUF) begin
        data_buf_ff <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // a16 pin select with pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      p1_a_ff <= 8'h00;
      p1_b_ff <= 8'h00;
      p1_c_ff <= 8'h00;
      a16_ff  <= 1'b0;
    end else begin
      p1_a_ff <= port1_in;
      p1_b_ff <= p1_a_ff;
      p1_c_ff <= p1_b_ff;
      if (p1_b_ff[bank_ctrl_ff[2:0]] == p1_c_ff[bank_ctrl_ff[2:0]]) begin
        a16_ff <= bank_ctrl_ff[`IFB_BIT_BANKING_EN] &
                  p1_c_ff[bank_ctrl_ff[2:0]];
      end
    end
  end
  assign code_addr_hi_sel = {a16_ff, 16'h0000};

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (s_axi_araddr[9:2])
      `IFB_ADDR_BANK_CTRL: rd_val = bank_ctrl_ff;
      `IFB_ADDR_ADDR_LO:   rd_val = addr_lo_ff;
      `IFB_ADDR_ADDR_HI:   rd_val = addr_hi_ff;
      `IFB_ADDR_DATA_BUF:  rd_val = data_buf_ff;
      `IFB_ADDR_OP_MODE:   rd_val = op_mode_ff;
      `IFB_ADDR_CHIP_CTRL: rd_val = {7'h00, prog_en_ff};
      `IFB_ADDR_STATUS:    rd_val = {5'h00, busy_err_ff, bad_op_ff, busy};
      default:             rd_val = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= known_addr(s_axi_araddr[9:2]) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/ifb_isp_flash_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checks
// ------------------------------
module ifb_isp_flash_chk #(
  parameter LD_AW = 12,
  parameter AP_AW = 16
) (
  // clock, reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // core side
  input wire logic        cpu_hold,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic [16:0] code_addr_hi_sel
);
  localparam int LIM = (1 << LD_AW) + (1 << AP_AW) + 16;
  logic [31:0] hold_cnt_ff;
  always @(posedge aclk) begin
    if (!aresetn || !cpu_hold) hold_cnt_ff <= 32'h0;
    else hold_cnt_ff <= hold_cnt_ff + 32'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ar_ready: assert property (
    s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  a_strobe_idle: assert property (
    !cpu_hold && !$past(cpu_hold) |-> flash_ce_n && flash_oe_n)
    else $error("strobe active while idle");
  a_a16_only: assert property (
    code_addr_hi_sel[15:0] == 16'h0)
    else $error("low select bits set");
  a_hold_bounded: assert property (
    hold_cnt_ff < LIM)
    else $error("core held too long");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !cpu_hold)
    else $error("outputs active after reset");
endmodule
bind ifb_isp_flash ifb_isp_flash_chk #(.LD_AW(LD_AW), .AP_AW(AP_AW))
  i_chk (.*);
`default_nettype wire

// ### tb/ifb_port1_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port 1 pin model
// ------------------------------
module ifb_port1_model (
  // levels wanted by the bench
  input  wire logic [7:0] level,
  // pins seen by the core
  output var  logic [7:0] pins
);
  // pins settle off the clock edge, like a board
  always @(level) pins <= #7 level;
endmodule
`default_nettype wire

// ### tb/tb_isp_flash_access_banking.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifb_defines.vh"
module tb_isp_flash_access_banking;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_hold;
  logic        flash_ce_n, flash_oe_n, pen;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [7:0]  port1_in, p1_lvl;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [16:0] code_addr_hi_sel;
  int          error_cnt, n_compared, a, mdl[3][4096], pa[12];
  logic [7:0]  ra[6] = '{8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hB4};
  logic [31:0] rv[6] = '{`IFB_RST_BANK_CTRL, 0, 0, 0, `IFB_RST_OP_MODE, 0};

  ifb_isp_flash #(.LD_AW(12), .AP_AW(8)) i_dut (.*);
  ifb_port1_model i_p1 (.level(p1_lvl), .pins(port1_in));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ------------------------------
  // bus tasks and checks
  // ------------------------------
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask
  task tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 5000) begin
      chk(0, 1, "wait ran out");
      tally_and_finish();
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= {ad, 2'b00};
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        tick(n);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
    end
  endtask
  task rdr(input logic [7:0] ad);
    int n;
    begin
      n = 0;
      s_axi_araddr <= {ad, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
        tick(n);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
    end
  endtask
  task at(input int ad);
    wr(8'hAC, ad & 255);
    wr(8'hAD, (ad >> 8) & 255);
  endtask
  // k: 0 first main bank, 1 second main bank, 2 loader array
  task run(input int k, input logic [3:0] c);
    int n;
    begin
      n = 0;
      wr(8'hAF, {24'h0, k == 1, k == 2, c != 4'h0, 1'b0, c});
      wr(8'hB8, 32'h1);
      if (c < 4'h3) chk(cpu_hold, pen, "hold");
      if (c < 4'h3) chk(flash_ce_n, !pen, "ce strobe");
      if (c < 4'h3) chk(flash_oe_n, !pen || c != 4'h0, "oe strobe");
      while (cpu_hold) tick(n);
    end
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    error_cnt = 0;
    n_compared = 0;
    aresetn = 1'b0;
    pen = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hF;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_wdata = 32'h0;
    p1_lvl = 8'h00;
    d = $urandom(43);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rdr(ra[i]);
      chk(rd, rv[i], "reset value");
    end
    for (int i = 1; i < 4; i++) begin
      d = $urandom_range(255);
      wr(ra[i], d);
      rdr(ra[i]);
      chk(rd, d, "read back");
    end
    wr(8'hC0, 32'h1);
    chk(rsp, 2'b10, "unmapped write");
    rdr(8'hC0);
    chk(rsp, 2'b10, "unmapped read");
    $display("test registers done");
    wr(8'hB4, 32'h1);
    pen = 1'b1;
    for (int k = 0; k < 3; k++) begin
      run(k, `IFB_OP_ERASE);
      for (int j = 0; j < 4096; j++) mdl[k][j] = 255;
    end
    for (int i = 0; i < 12; i++) begin
      pa[i] = $urandom_range(i / 4 == 2 ? 4095 : 255);
      d = $urandom_range(255);
      at(pa[i]);
      wr(8'hAE, d);
      run(i / 4, `IFB_OP_PROGRAM);
      mdl[i / 4][pa[i]] = d;
    end
    run(0, 4'h5);
    rdr(8'hBC);
    chk(rd[1], 1'b1, "bad op flag");
    for (int i = 0; i < 36; i++) begin
      a = pa[i % 12] & (i / 12 == 2 ? 4095 : 255);
      at(a);
      run(i / 12, `IFB_OP_READ);
      rdr(8'hAE);
      chk(rd, mdl[i / 12][a], "flash read");
    end
    wr(8'hAE, 32'h5A);
    wr(8'hB4, 32'h0);
    pen = 1'b0;
    run(2, `IFB_OP_READ);
    rdr(8'hAE);
    chk(rd, 32'h5A, "idle outside mode");
    $display("test flash done");
    for (int i = 0; i < 17; i++) begin
      d = $urandom_range(255);
      wr(8'hAB, {28'h0, i < 16, i[2:0]});
      p1_lvl <= i[3] ? ~d[7:0] : d[7:0];
      repeat (8) @(posedge aclk);
      chk(code_addr_hi_sel, {i < 16 && p1_lvl[i % 8], 16'h0}, "a16");
    end
    $display("test banking done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
